// File: common/osc_defines.svh
// Timing counts, default mode encoding and fixed values for the main oscillator mode selector.
// Assumes the system clock period given below; the start-up and PLL lock counts derive from it.
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

`define CLK_SYS_PERIOD_PS 5000
`define EXT_CLK_STARTUP_NS 1500
`define EXT_CLK_STARTUP_CYCLES ((`EXT_CLK_STARTUP_NS * 1000) / `CLK_SYS_PERIOD_PS)
`define STARTUP_OVERHEAD_CYCLES 4
`define PLL_LOCK_TIMEOUT_US 2000
`define PLL_LOCK_CYCLES ((`PLL_LOCK_TIMEOUT_US * 1000000) / `CLK_SYS_PERIOD_PS)
`define TIMER_W 20
`define MODE_CODE_W 3
`define MODE_ENCODING_DEFAULT 24'hfac688
`define PLL_MULT_FACTOR 3'h4
`define DIRECT_MULT_FACTOR 3'h1

`endif

// File: common/osc_pkg.sv
// Types shared by the main oscillator mode selector and its bench.
// Assumes nothing beyond the defines header.
package osc_pkg;

  typedef enum logic [2:0] {
    low_power_crystal_mode,
    crystal_medium_mode,
    high_speed_crystal_mode,
    high_speed_crystal_x4_mode,
    resistor_capacitor_osc_mode,
    resistor_capacitor_gpio_mode,
    external_clock_mode,
    external_clock_gpio_mode
  } osc_mode_t;

  typedef enum logic [2:0] {
    s_settle_a,
    s_settle_b,
    s_capture,
    s_wait,
    s_run,
    s_secondary
  } osc_state_t;

endpackage : osc_pkg

// File: rtl/startup_timer.sv
// Down counter that holds busy for exactly the loaded number of cycles.
// Assumes load_i is a single-cycle request from logic on the same clock.
`timescale 1ns/1ps
`include "osc_defines.svh"

module startup_timer (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [`TIMER_W-1:0] load_value_i,
  output logic busy_o
);

  logic [`TIMER_W-1:0] count;
  logic [`TIMER_W-1:0] next_count;
  logic busy;
  logic next_busy;

  always_comb begin
    next_count = count;
    next_busy = busy;
    if (load_i) begin
      next_count = load_value_i;
      next_busy = (load_value_i != '0);
    end else if (busy) begin
      next_count = count - `TIMER_W'(1);
      next_busy = (count != `TIMER_W'(1));
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
      busy <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
    end
  end

  assign busy_o = busy;

  property p_busy_ends;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (busy && count == `TIMER_W'(1) && !load_i) |=> !busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("timer did not end at count one");

endmodule : startup_timer

// File: rtl/osc_mode_select.sv
// Main oscillator mode selector: latches the mode field, steers the clock pins and PLL, gates execution.
// Assumes pins arrive asynchronously; the analog amplifier and PLL act on the enables driven here.
`timescale 1ns/1ps
`include "osc_defines.svh"

module osc_mode_select
  import osc_pkg::*;
#(
  parameter logic [23:0] MODE_ENCODING = `MODE_ENCODING_DEFAULT,
  parameter int PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [`MODE_CODE_W-1:0] osc_mode_config_field_i,
  input wire logic secondary_osc_active_i,
  input wire logic wake_from_sleep_i,
  input wire logic clock_in_pin_i,
  input wire logic clock_out_pin_i,
  output logic clock_out_pin_o,
  output logic clock_out_pin_oe_o,
  input wire logic port_a_bit6_io_out_i,
  input wire logic port_a_bit6_io_oe_i,
  output logic port_a_bit6_io_in_o,
  output logic feedback_amp_en_o,
  output logic pll_en_o,
  output logic [2:0] clk_mult_factor_o,
  output logic [2:0] osc_mode_o,
  output logic exec_enable_o
);

  // Settle, capture and hand-over edges eat into the start-up budget, so the timer gets only the rest
  localparam int EXT_STARTUP_CYCLES = (`EXT_CLK_STARTUP_CYCLES <= `STARTUP_OVERHEAD_CYCLES) ? 1 :
                                      (`EXT_CLK_STARTUP_CYCLES - `STARTUP_OVERHEAD_CYCLES);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic osc_mode_t decode_mode(input logic [`MODE_CODE_W-1:0] code);
    osc_mode_t m;
    m = low_power_crystal_mode;
    // Lowest-index match wins if the parameter repeats a code
    for (int i = 7; i >= 0; i--) begin
      if (MODE_ENCODING[i*3 +: 3] == code) begin
        m = osc_mode_t'(3'(i));
      end
    end
    return m;
  endfunction : decode_mode

  function automatic logic is_ext(input osc_mode_t m);
    return (m == external_clock_mode) || (m == external_clock_gpio_mode);
  endfunction : is_ext

  function automatic logic is_gpio(input osc_mode_t m);
    return (m == resistor_capacitor_gpio_mode) || (m == external_clock_gpio_mode);
  endfunction : is_gpio

  function automatic logic is_crystal(input osc_mode_t m);
    return (m == low_power_crystal_mode) || (m == crystal_medium_mode) ||
           (m == high_speed_crystal_mode) || (m == high_speed_crystal_x4_mode);
  endfunction : is_crystal

  function automatic logic [`TIMER_W-1:0] wait_cycles(input osc_mode_t m);
    if (m == high_speed_crystal_x4_mode) begin
      return `TIMER_W'(PLL_LOCK_CYCLES);
    end else if (is_ext(m)) begin
      return `TIMER_W'(EXT_STARTUP_CYCLES);
    end
    return '0;
  endfunction : wait_cycles

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [`MODE_CODE_W-1:0] cfg_meta;
  logic [`MODE_CODE_W-1:0] cfg_sync;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic clk_in_prev;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_meta <= '0;
      cfg_sync <= '0;
      pin_meta <= '0;
      pin_sync <= '0;
      clk_in_prev <= 1'b0;
    end else begin
      cfg_meta <= osc_mode_config_field_i;
      cfg_sync <= cfg_meta;
      pin_meta <= {clock_out_pin_i, wake_from_sleep_i, secondary_osc_active_i, clock_in_pin_i};
      pin_sync <= pin_meta;
      clk_in_prev <= pin_sync[0];
    end
  end

  logic clk_in_s;
  logic sec_s;
  logic wake_s;
  logic clock_out_pin_in_s;
  logic clk_in_rise;

  assign clk_in_s = pin_sync[0];
  assign sec_s = pin_sync[1];
  assign wake_s = pin_sync[2];
  assign clock_out_pin_in_s = pin_sync[3];
  assign clk_in_rise = clk_in_s && !clk_in_prev;

  // ----------------------------------------------------------------
  // Mode latch and start-up sequencing
  // ----------------------------------------------------------------
  osc_state_t state;
  osc_state_t next_state;
  osc_mode_t mode;
  osc_mode_t next_mode;
  logic exec_en;
  logic next_exec_en;
  logic timer_load;
  logic [`TIMER_W-1:0] timer_load_value;
  logic timer_busy;
  logic wake_prev;

  always_comb begin
    next_state = state;
    next_mode = mode;
    timer_load = 1'b0;
    timer_load_value = '0;
    unique case (state)
      s_settle_a: begin
        next_state = s_settle_b;
      end
      s_settle_b: begin
        next_state = s_capture;
      end
      s_capture: begin
        // Field sampled only here: after reset or on return from the secondary clock
        next_mode = decode_mode(cfg_sync);
        timer_load = 1'b1;
        timer_load_value = wait_cycles(next_mode);
        next_state = s_wait;
      end
      s_wait: begin
        if (!timer_busy) begin
          next_state = s_run;
        end
      end
      s_run: begin
        if (sec_s) begin
          next_state = s_secondary;
        end else if (wake_s && !wake_prev && is_ext(mode)) begin
          timer_load = 1'b1;
          timer_load_value = wait_cycles(mode);
          next_state = s_wait;
        end
      end
      s_secondary: begin
        if (!sec_s) begin
          next_state = s_capture;
        end
      end
    endcase
    next_exec_en = (next_state == s_run) || (next_state == s_secondary);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= s_settle_a;
      mode <= low_power_crystal_mode;
      exec_en <= 1'b0;
      wake_prev <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      exec_en <= next_exec_en;
      wake_prev <= wake_s;
    end
  end

  startup_timer u_startup_timer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .load_i(timer_load),
    .load_value_i(timer_load_value),
    .busy_o(timer_busy)
  );

  // ----------------------------------------------------------------
  // Pin steering, divider and analog enables
  // ----------------------------------------------------------------
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic clk_out;
  logic next_clk_out;
  logic clk_out_oe;
  logic next_clk_out_oe;
  logic gpio_in;
  logic next_gpio_in;
  logic fb_en;
  logic next_fb_en;
  logic pll_en;
  logic next_pll_en;

  always_comb begin
    // Divider counts clock-in edges; sampling limits the input to below half of clk_sys
    next_div_cnt = clk_in_rise ? div_cnt + 2'h1 : div_cnt;
    next_clk_out = 1'b0;
    next_clk_out_oe = 1'b0;
    next_gpio_in = 1'b0;
    next_fb_en = 1'b0;
    next_pll_en = (state == s_capture) ? (next_mode == high_speed_crystal_x4_mode) : pll_en;
    if (state != s_settle_a && state != s_settle_b && state != s_capture) begin
      if (is_gpio(mode)) begin
        next_clk_out = port_a_bit6_io_out_i;
        next_clk_out_oe = port_a_bit6_io_oe_i;
        next_gpio_in = clock_out_pin_in_s;
      end else if (!is_crystal(mode)) begin
        next_clk_out = div_cnt[1];
        next_clk_out_oe = 1'b1;
      end
      // Crystal modes leave the pin to the amplifier; RC and external clock modes keep the amplifier off
      next_fb_en = is_crystal(mode);
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 2'h0;
      clk_out <= 1'b0;
      clk_out_oe <= 1'b0;
      gpio_in <= 1'b0;
      fb_en <= 1'b0;
      pll_en <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      clk_out <= next_clk_out;
      clk_out_oe <= next_clk_out_oe;
      gpio_in <= next_gpio_in;
      fb_en <= next_fb_en;
      pll_en <= next_pll_en;
    end
  end

  assign clock_out_pin_o = clk_out;
  assign clock_out_pin_oe_o = clk_out_oe;
  assign port_a_bit6_io_in_o = gpio_in;
  assign feedback_amp_en_o = fb_en;
  assign pll_en_o = pll_en;
  assign clk_mult_factor_o = pll_en ? `PLL_MULT_FACTOR : `DIRECT_MULT_FACTOR;
  assign osc_mode_o = mode;
  assign exec_enable_o = exec_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mode_decode;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      ($past(state) == s_capture) |-> (mode == decode_mode($past(cfg_sync)));
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode not decoded from field");

  property p_mode_fixed;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      ($past(state) != s_capture) |-> $stable(mode);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed at run time");

  property p_crystal_pin;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == s_run && is_crystal(mode)) |=> (!clock_out_pin_oe_o && feedback_amp_en_o);
  endproperty
  a_crystal_pin: assert property (p_crystal_pin) else $error("crystal mode pin misdriven");

  property p_div_step;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      clk_in_rise |=> (div_cnt == $past(div_cnt) + 2'h1);
  endproperty
  a_div_step: assert property (p_div_step) else $error("divider missed a clock-in edge");

  property p_div_out;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == s_run && !is_crystal(mode) && !is_gpio(mode)) |=> (clock_out_pin_oe_o && clock_out_pin_o == $past(div_cnt[1]));
  endproperty
  a_div_out: assert property (p_div_out) else $error("quarter clock not on clock-out pin");

  property p_gpio_pin;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == s_run && is_gpio(mode)) |=> (clock_out_pin_oe_o == $past(port_a_bit6_io_oe_i) &&
                                             clock_out_pin_o == $past(port_a_bit6_io_out_i));
  endproperty
  a_gpio_pin: assert property (p_gpio_pin) else $error("port bit not routed to clock-out pin");

  property p_ext_amp_off;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (is_ext(mode) && $past(is_ext(mode))) |-> !feedback_amp_en_o;
  endproperty
  a_ext_amp_off: assert property (p_ext_amp_off) else $error("amplifier on in external mode");

  sequence s_wait_entry;
    (state == s_wait) && ($past(state) != s_wait);
  endsequence

  property p_ext_startup;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (s_wait_entry and is_ext(mode)) |-> ##[1:297] exec_enable_o;
  endproperty
  a_ext_startup: assert property (p_ext_startup) else $error("external clock start-up too long");

  property p_pll_only_hs;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == s_run) |-> (pll_en_o == (mode == high_speed_crystal_x4_mode) &&
                            clk_mult_factor_o == (pll_en_o ? 3'h4 : 3'h1));
  endproperty
  a_pll_only_hs: assert property (p_pll_only_hs) else $error("PLL enable disagrees with mode");

  property p_pll_no_fly;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      $changed(pll_en_o) |-> ($past(state) == s_capture);
  endproperty
  a_pll_no_fly: assert property (p_pll_no_fly) else $error("PLL enable changed on the fly");

  property p_hold_exec;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (state == s_wait) |-> !exec_enable_o;
  endproperty
  a_hold_exec: assert property (p_hold_exec) else $error("execution during lock wait");

  property p_pll_timeout;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (timer_load && next_mode == high_speed_crystal_x4_mode && state == s_capture) |->
        (timer_load_value == `TIMER_W'(PLL_LOCK_CYCLES));
  endproperty
  a_pll_timeout: assert property (p_pll_timeout) else $error("wrong PLL lock timeout loaded");

endmodule : osc_mode_select

// File: sim/clock_source_model.sv
// Behavioural source on the clock-in pin: crystal, resonator, RC network or oscillator.
// Assumes the bench gives the half period in system clock cycles, well below clk_sys/4.
`timescale 1ns/1ps

module clock_source_model (
  input wire logic clk_sys_i,
  input wire logic run_i,
  input wire logic [7:0] half_i,
  output logic clock_o
);
  logic [7:0] count;

  // Stands low while stopped, as a stalled source would
  always @(posedge clk_sys_i) begin
    if (!run_i) begin
      clock_o <= 1'b0;
      count <= 8'h00;
    end else if (count >= half_i - 8'h01) begin
      clock_o <= ~clock_o;
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule : clock_source_model

// File: sim/main_oscillator_mode_select_bench.sv
// Self-checking bench for the main oscillator mode selector.
// Assumes the reversed code table below and a short lock count.
`timescale 1ns/1ps
`include "osc_defines.svh"

module main_oscillator_mode_select_bench;
  import osc_pkg::*;
  localparam int LOCK = 50;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [2:0] field = 3'h0;
  logic secondary = 1'b0;
  logic wake = 1'b0;
  logic run = 1'b0;
  logic gp_out = 1'b0;
  logic gp_oe = 1'b0;
  logic ext_level = 1'b0;
  logic clk_in, pin, pin_o, pin_oe, gp_in, amp, pll, exec;
  logic [2:0] mult, mode;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h9030a025;

  always #2.5 clk_sys_i = ~clk_sys_i;
  // Wire level: device when it drives, else the far side
  assign pin = pin_oe ? pin_o : ext_level;

  clock_source_model source (.clk_sys_i(clk_sys_i), .run_i(run), .half_i(8'h06), .clock_o(clk_in));

  // Reversed table so that an identity mapping shows up as a fault
  osc_mode_select #(.MODE_ENCODING(24'h053977), .PLL_LOCK_CYCLES(LOCK)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .osc_mode_config_field_i(field),
    .secondary_osc_active_i(secondary), .wake_from_sleep_i(wake), .clock_in_pin_i(clk_in),
    .clock_out_pin_i(pin), .clock_out_pin_o(pin_o), .clock_out_pin_oe_o(pin_oe),
    .port_a_bit6_io_out_i(gp_out), .port_a_bit6_io_oe_i(gp_oe), .port_a_bit6_io_in_o(gp_in),
    .feedback_amp_en_o(amp), .pll_en_o(pll), .clk_mult_factor_o(mult), .osc_mode_o(mode),
    .exec_enable_o(exec)
  );

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand

  function automatic logic [2:0] code_of(int m);
    return 3'(7 - m);
  endfunction : code_of

  function automatic logic is_ext(int m);
    return m >= 6;
  endfunction : is_ext

  function automatic logic is_gpio(int m);
    return m == 5 || m == 7;
  endfunction : is_gpio

  function automatic int start_min(int m);
    return m == 3 ? LOCK : is_ext(m) ? `EXT_CLK_STARTUP_CYCLES - 8 : 1;
  endfunction : start_min

  // External modes must be running within the full start-up budget
  function automatic int start_max(int m);
    return m == 3 ? LOCK + 8 : is_ext(m) ? `EXT_CLK_STARTUP_CYCLES : 8;
  endfunction : start_max

  // ----------------------------------------
  // Compare and sequencing tasks
  // ----------------------------------------
  task automatic check_bit(string what, logic got, logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_code(string what, logic [2:0] got, logic [2:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : check_code

  task automatic check_range(string what, int got, int lo, int hi);
    check_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("unexpected at %0t: %s %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : check_range

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cycles(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cycles

  // Bounded wait for execution to be allowed
  task automatic wait_exec(output int n);
    n = 0;
    while (exec !== 1'b1 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 2000) begin
      bad_count++;
      $display("unexpected at %0t: execution never enabled", $time);
      end_of_test();
    end
  endtask : wait_exec

  task automatic start(int m);
    int n;
    field = code_of(m);
    reset_n_i = 1'b0;
    cycles(8);
    reset_n_i = 1'b1;
    wait_exec(n);
    check_range("start-up cycles", n, start_min(m), start_max(m));
  endtask : start

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n, rises;
    logic prev;
    logic [31:0] rnd;
    @(negedge clk_sys_i);
    run = 1'b1;
    for (int m = 0; m < 8; m++) begin
      start(m);
      check_code("mode", mode, 3'(m));
      check_bit("pll enable", pll, m == 3);
      check_code("multiplier", mult, m == 3 ? 3'h4 : 3'h1);
      check_bit("amplifier", amp, m < 4);
      field = code_of(m ^ 1);
      cycles(6);
      check_code("mode after field change", mode, 3'(m));
      if (m < 4) begin
        check_bit("crystal pin drive", pin_oe, 1'b0);
      end else if (!is_gpio(m)) begin
        check_bit("quarter clock drive", pin_oe, 1'b1);
        rises = 0;
        prev = pin_o;
        repeat (768) begin
          @(negedge clk_sys_i);
          if (pin_o && !prev) rises++;
          prev = pin_o;
        end
        check_range("quarter clock edges", rises, 15, 17);
      end else begin
        repeat (6) begin
          rnd = next_rand();
          {gp_out, gp_oe, ext_level} = rnd[2:0];
          cycles(5);
          check_bit("port pin drive", pin_oe, gp_oe);
          check_bit("port pin value", pin_o, gp_out);
          check_bit("port pin read", gp_in, gp_oe ? gp_out : ext_level);
        end
        gp_oe = 1'b0;
      end
      if (!is_gpio(m)) check_bit("port read idle", gp_in, 1'b0);
      if (m == 6) begin
        wake = 1'b1;
        cycles(3);
        wake = 1'b0;
        n = 0;
        while (exec !== 1'b0 && n < 10) begin
          @(negedge clk_sys_i);
          n++;
        end
        check_bit("held after wake", exec, 1'b0);
        wait_exec(n);
        // Three cycles already spent holding the wake pin
        check_range("wake start-up cycles", n, `EXT_CLK_STARTUP_CYCLES - 10, `EXT_CLK_STARTUP_CYCLES - 3);
      end
      if (m == 3) begin
        secondary = 1'b1;
        field = code_of(2);
        cycles(8);
        check_code("mode on secondary", mode, 3'h3);
        secondary = 1'b0;
        cycles(LOCK + 20);
        check_code("mode on return", mode, 3'h2);
        check_bit("pll after return", pll, 1'b0);
        check_bit("exec after return", exec, 1'b1);
      end
      $display("test mode %0d done", m);
    end
    end_of_test();
  end
endmodule : main_oscillator_mode_select_bench
